// *** verilog/dasel_pkg.sv ***
/*
 * constants for the activation source selector: factor codes, field widths, reset values.
 * assumes nothing of its surroundings; used by every design file through package::name.
 */
package dasel_pkg;
  localparam int FACTOR_W = 4;
  localparam int SERIAL_UNITS = 2;
  localparam int TIMER_UNITS = 3;
  localparam int CHANNELS = 2;
  localparam logic [3:0] FACTOR_RST = 4'h0;
  localparam logic BLOCK_EN_RST = 1'b0;
  localparam logic BLOCK_SIDE_RST = 1'b0;
  // normal mode codes
  localparam logic [3:0] F_AUTO_STEAL = 4'h6;
  localparam logic [3:0] F_AUTO_BURST = 4'h7;
  // block transfer mode codes
  localparam logic [3:0] F_ADC_END = 4'h1;
  localparam logic [3:0] F_USB_REQ = 4'h3;
  localparam logic [3:0] F_SERIAL_FIRST = 4'h4;
  localparam logic [3:0] F_SERIAL_LAST = 4'h7;
  localparam logic [3:0] F_TIMER_FIRST = 4'h8;
  localparam logic [3:0] F_TIMER_LAST = 4'ha;
endpackage : dasel_pkg

// *** verilog/dasel_dec_if.sv ***
/*
 * per-channel link between the selector top and one factor decoder.
 * assumes the top fills the inputs from its own registers and the peripheral event lines.
 */
`timescale 1ns/10ps
interface dasel_dec_if;
  logic [3:0] factor;
  logic block_mode_enable;
  logic adc_conv_end;
  logic usb_dma_request_line_b;
  logic [dasel_pkg::SERIAL_UNITS-1:0] serial_tx_done;
  logic [dasel_pkg::SERIAL_UNITS-1:0] serial_rx_done;
  logic [dasel_pkg::TIMER_UNITS-1:0] timer_match_a;
  logic req;
  logic burst;
  logic code_valid;
  modport ctl (output factor, block_mode_enable, adc_conv_end, usb_dma_request_line_b, serial_tx_done,
    serial_rx_done, timer_match_a, input req, burst, code_valid);
  modport dec (input factor, block_mode_enable, adc_conv_end, usb_dma_request_line_b, serial_tx_done,
    serial_rx_done, timer_match_a, output req, burst, code_valid);
endinterface : dasel_dec_if

// *** verilog/dasel_decode.sv ***
/*
 * combinational factor decoder for one channel: picks the activation source from the factor code.
 * assumes event inputs are synchronous to ref_clk; the owning top registers the result.
 */
`timescale 1ns/10ps
module dasel_decode (
  dasel_dec_if.dec d
);
  logic [3:0] serial_idx;
  logic [3:0] timer_idx;

  always_comb begin
    serial_idx = d.factor - dasel_pkg::F_SERIAL_FIRST;
    timer_idx = d.factor - dasel_pkg::F_TIMER_FIRST;
    d.req = 1'b0;
    d.burst = 1'b0;
    d.code_valid = 1'b0;
    if (!d.block_mode_enable) begin
      if (d.factor == dasel_pkg::F_AUTO_STEAL || d.factor == dasel_pkg::F_AUTO_BURST) begin
        d.req = 1'b1;
        d.code_valid = 1'b1;
        d.burst = (d.factor == dasel_pkg::F_AUTO_BURST);
      end
    end else begin
      if (d.factor == dasel_pkg::F_ADC_END) begin
        d.req = d.adc_conv_end;
        d.code_valid = 1'b1;
      end else if (d.factor == dasel_pkg::F_USB_REQ) begin
        d.req = !d.usb_dma_request_line_b;
        d.code_valid = 1'b1;
      end else if (d.factor >= dasel_pkg::F_SERIAL_FIRST && d.factor <= dasel_pkg::F_SERIAL_LAST) begin
        // even offsets are transmit, odd are receive, unit = offset / 2
        d.req = serial_idx[0] ? d.serial_rx_done[serial_idx[1]] : d.serial_tx_done[serial_idx[1]];
        d.code_valid = 1'b1;
      end else if (d.factor >= dasel_pkg::F_TIMER_FIRST && d.factor <= dasel_pkg::F_TIMER_LAST) begin
        d.req = d.timer_match_a[timer_idx[1:0]];
        d.code_valid = 1'b1;
      end
    end
    // any other code leaves req and code_valid low
  end
endmodule : dasel_decode

// *** verilog/dasel_top.sv ***
/*
 * activation source selection for the full-address-mode channels of a dma controller.
 * assumes the transfer engine consumes one start pulse per cycle and drives chan_enable;
 * event inputs are single-cycle pulses synchronous to ref_clk, the usb line is a level.
 */
// Functional notes
// - each channel keeps a 4-bit read/write activation factor that resets to zero.
// - in normal mode code 0110 is an auto-request in cycle-steal form and 0111 in burst form.
// - the factor code is read through the normal-mode table or the block-mode table by mode.
// - in block mode code 0001 starts on the converter's conversion-end event.
// - in block mode code 0011 starts while the usb request line is held low.
// - in block mode codes 0100 to 0111 start on serial unit 0 tx, 0 rx, 1 tx, 1 rx complete.
// - in block mode codes 1000, 1001, 1010 start on timer channel 0, 1, 2 compare/capture A.
// - channels may share a factor and the highest-priority requester is started first.
// - the block enable bit selects block mode and the side bit selects the block area; here the side bit is only stored and read back on block_side_select.
`timescale 1ns/10ps
module dasel_top #(
  parameter int NCH = dasel_pkg::CHANNELS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // configuration write port, one strobe per channel
  input wire logic [NCH-1:0] cfg_wr_en,
  input wire logic [3:0] cfg_wr_factor,
  input wire logic cfg_wr_block_mode_enable,
  input wire logic cfg_wr_block_side_select,
  // transfer engine
  input wire logic [NCH-1:0] chan_enable,
  // peripheral activation events
  input wire logic adc_conv_end,
  input wire logic usb_dma_request_line_b,
  input wire logic [dasel_pkg::SERIAL_UNITS-1:0] serial_tx_done,
  input wire logic [dasel_pkg::SERIAL_UNITS-1:0] serial_rx_done,
  input wire logic [dasel_pkg::TIMER_UNITS-1:0] timer_match_a,
  // configuration readback
  output logic [NCH-1:0][3:0] activation_factor,
  output logic [NCH-1:0] block_mode_enable,
  output logic [NCH-1:0] block_side_select,
  // activation results
  output logic [NCH-1:0] code_valid,
  output logic [NCH-1:0] start,
  output logic [NCH-1:0] start_burst
);
  typedef struct packed {
    logic [NCH-1:0][3:0] factor;
    logic [NCH-1:0] blk;
    logic [NCH-1:0] side;
    logic [NCH-1:0] valid;
    logic [NCH-1:0] pending;
    logic [NCH-1:0] start;
    logic [NCH-1:0] burst;
  } dasel_state_t;

  dasel_state_t state_reg;
  dasel_state_t state_next;
  logic [NCH-1:0] req;
  logic [NCH-1:0] burst_sel;
  logic [NCH-1:0] valid_sel;
  logic [NCH-1:0] grant;

  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("dasel_top: NCH must be 1 to 8");
  end

  // lowest index is the highest relative priority
  function automatic logic [NCH-1:0] dasel_first(input logic [NCH-1:0] v);
    logic [NCH-1:0] r;
    logic found;
    r = '0;
    found = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (v[i] && !found) begin
        r[i] = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction : dasel_first

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      dasel_dec_if dif ();
      assign dif.factor = state_reg.factor[g];
      assign dif.block_mode_enable = state_reg.blk[g];
      assign dif.adc_conv_end = adc_conv_end;
      assign dif.usb_dma_request_line_b = usb_dma_request_line_b;
      assign dif.serial_tx_done = serial_tx_done;
      assign dif.serial_rx_done = serial_rx_done;
      assign dif.timer_match_a = timer_match_a;
      assign req[g] = dif.req;
      assign burst_sel[g] = dif.burst;
      assign valid_sel[g] = dif.code_valid;
      dasel_decode u_dec (
        .d(dif.dec)
      );
    end
  endgenerate

  assign grant = dasel_first(state_reg.pending);

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NCH; i++) begin
      if (cfg_wr_en[i]) begin
        state_next.factor[i] = cfg_wr_factor;
        state_next.blk[i] = cfg_wr_block_mode_enable;
        state_next.side[i] = cfg_wr_block_side_select;
      end
      // a new request in the grant cycle survives: set wins over clear
      state_next.pending[i] = chan_enable[i] && valid_sel[i]
        && (req[i] || (state_reg.pending[i] && !grant[i]));
    end
    state_next.valid = valid_sel;
    state_next.start = grant;
    state_next.burst = grant & burst_sel;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg.factor <= {NCH{dasel_pkg::FACTOR_RST}};
      state_reg.blk <= {NCH{dasel_pkg::BLOCK_EN_RST}};
      state_reg.side <= {NCH{dasel_pkg::BLOCK_SIDE_RST}};
      state_reg.valid <= '0;
      state_reg.pending <= '0;
      state_reg.start <= '0;
      state_reg.burst <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign activation_factor = state_reg.factor;
  assign block_mode_enable = state_reg.blk;
  assign block_side_select = state_reg.side;
  assign code_valid = state_reg.valid;
  assign start = state_reg.start;
  assign start_burst = state_reg.burst;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_cfg_written(int i);
    cfg_wr_en[i] ##1 1'b1;
  endsequence

  // an event taken at one edge is pending after it and shows as start after the next one
  sequence s_start0_after_take;
    ##2 start[0];
  endsequence

  sequence s_quiet0_after_take;
    ##2 !start[0];
  endsequence

  // reset itself is what this one watches, so it is never disabled
  a_reset_clear: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_b |=> activation_factor == '0 && block_mode_enable == '0 && start == '0 && code_valid == '0
  ) else $error("reset did not clear the channel state");

  // configuration storage
  a_factor_store: assert property (
    cfg_wr_en[0] |=> activation_factor[0] == $past(cfg_wr_factor)
  ) else $error("factor write not stored");
  a_mode_store: assert property (
    s_cfg_written(0) |-> block_mode_enable[0] == $past(cfg_wr_block_mode_enable)
  ) else $error("mode bit not stored");
  a_side_store: assert property (
    cfg_wr_en[0] |=> block_side_select[0] == $past(cfg_wr_block_side_select)
  ) else $error("side bit not stored");

  // one start per cycle, lowest index first
  a_start_onehot: assert property ($onehot0(start)) else $error("more than one channel started");
  a_prio_order: assert property (
    state_reg.pending[0] |=> start[0]
  ) else $error("top priority channel not started first");
  a_shared_factor: assert property (
    (NCH > 1 && state_reg.pending[0] && state_reg.pending[NCH-1]) |=> start[0] && !start[NCH-1]
  ) else $error("shared factor started lower priority channel first");
  a_disabled_quiet: assert property (
    !chan_enable[NCH-1] |-> ##2 !start[NCH-1]
  ) else $error("disabled channel started");

  // normal-mode auto-request
  a_burst_code: assert property (
    start_burst[0] |-> start[0] && !$past(state_reg.blk[0]) && $past(state_reg.factor[0]) == dasel_pkg::F_AUTO_BURST
  ) else $error("burst start without burst code");
  a_steal_form: assert property (
    (!state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_AUTO_STEAL) |=> !start_burst[0]
  ) else $error("cycle steal code started a burst");
  a_auto_start: assert property (
    (!state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_AUTO_STEAL && chan_enable[0]
      && $stable(state_reg.factor[0]) && !cfg_wr_en[0])[*3] |-> ##[0:2] start[0]
  ) else $error("auto request never started");

  // block-mode event sources
  a_adc_start: assert property (
    (state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_ADC_END && chan_enable[0] && adc_conv_end) |-> s_start0_after_take
  ) else $error("conversion end did not start channel");
  a_usb_start: assert property (
    (state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_USB_REQ && chan_enable[0] && !usb_dma_request_line_b) |-> s_start0_after_take
  ) else $error("usb low level did not start channel");
  a_serial_start: assert property (
    (state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_SERIAL_LAST && chan_enable[0] && serial_rx_done[1]) |-> s_start0_after_take
  ) else $error("serial receive complete did not start channel");
  a_timer_start: assert property (
    (state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_TIMER_LAST && chan_enable[0]
      && timer_match_a[dasel_pkg::TIMER_UNITS-1]) |-> s_start0_after_take
  ) else $error("timer event did not start channel");

  // code tables and unassigned codes
  a_invalid_idle: assert property (
    (!code_valid[0])[*2] |-> !start[0]
  ) else $error("unassigned code activated channel");
  a_normal_adc_idle: assert property (
    (!state_reg.blk[0] && state_reg.factor[0] == dasel_pkg::F_ADC_END) |-> s_quiet0_after_take
  ) else $error("converter code started channel in normal mode");
  a_block_no_burst: assert property (
    state_reg.blk[0] |=> !start_burst[0]
  ) else $error("burst start in block mode");
  a_adc_valid: assert property (
    (cfg_wr_en[0] && cfg_wr_block_mode_enable && cfg_wr_factor == dasel_pkg::F_ADC_END) |=> ##1 code_valid[0]
  ) else $error("adc code not valid in block mode");
  a_mode_table: assert property (
    (cfg_wr_en[0] && !cfg_wr_block_mode_enable && cfg_wr_factor == dasel_pkg::F_TIMER_FIRST) |=> ##1 !code_valid[0]
  ) else $error("timer code accepted in normal mode");
endmodule : dasel_top

// *** test/dasel_periph_model.sv ***
/*
 * peripheral side model: raises one activation event, or all of them, one cycle after a bench request.
 * assumes fire and sel are driven just after a rising edge of ref_clk.
 */
`timescale 1ns/10ps
module dasel_periph_model (
  // clock
  input wire logic ref_clk,
  // bench request: source code to raise, 4'h0 raises every source
  input wire logic fire,
  input wire logic [3:0] sel,
  // event lines
  output logic adc_conv_end = 1'b0,
  output logic usb_dma_request_line_b = 1'b1,
  output logic [1:0] serial_tx_done = 2'h0,
  output logic [1:0] serial_rx_done = 2'h0,
  output logic [2:0] timer_match_a = 3'h0
);
  function automatic logic hit(input logic [3:0] c);
    return fire && (sel == c || sel == 4'h0);
  endfunction : hit

  always @(posedge ref_clk) begin
    adc_conv_end <= hit(4'h1);
    // idle high, pulled low only to request
    usb_dma_request_line_b <= !hit(4'h3);
    serial_tx_done <= {hit(4'h6), hit(4'h4)};
    serial_rx_done <= {hit(4'h7), hit(4'h5)};
    timer_match_a <= {hit(4'ha), hit(4'h9), hit(4'h8)};
  end
endmodule : dasel_periph_model

// *** test/tb_top.sv ***
/*
 * self-checking bench for the activation source selector with two channels.
 * assumes the peripheral model and the design files are compiled first.
 */
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] cfg_wr_en = 2'h0;
  logic [3:0] cfg_wr_factor = 4'h0;
  logic cfg_wr_block_mode_enable = 1'b0;
  logic cfg_wr_block_side_select = 1'b0;
  logic [1:0] chan_enable = 2'h3;
  logic fire = 1'b0;
  logic [3:0] sel = 4'h0;
  logic adc_conv_end, usb_dma_request_line_b;
  logic [1:0] serial_tx_done, serial_rx_done;
  logic [2:0] timer_match_a;
  logic [1:0][3:0] activation_factor;
  logic [1:0] block_mode_enable, block_side_select, code_valid, start, start_burst;
  int fail_count = 0;
  int cmp_count = 0;

  always #20 ref_clk = ~ref_clk;

  dasel_top #(.NCH(2)) i_dasel_top (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_factor(cfg_wr_factor), .cfg_wr_block_mode_enable(cfg_wr_block_mode_enable),
    .cfg_wr_block_side_select(cfg_wr_block_side_select), .chan_enable(chan_enable),
    .adc_conv_end(adc_conv_end), .usb_dma_request_line_b(usb_dma_request_line_b),
    .serial_tx_done(serial_tx_done), .serial_rx_done(serial_rx_done), .timer_match_a(timer_match_a),
    .activation_factor(activation_factor), .block_mode_enable(block_mode_enable),
    .block_side_select(block_side_select), .code_valid(code_valid), .start(start), .start_burst(start_burst));

  dasel_periph_model i_dasel_periph_model (.ref_clk(ref_clk), .fire(fire), .sel(sel),
    .adc_conv_end(adc_conv_end), .usb_dma_request_line_b(usb_dma_request_line_b),
    .serial_tx_done(serial_tx_done), .serial_rx_done(serial_rx_done), .timer_match_a(timer_match_a));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [1:0] ch, input logic [3:0] f, input logic blk, input logic side);
    @(posedge ref_clk);
    cfg_wr_en <= ch;
    cfg_wr_factor <= f;
    cfg_wr_block_mode_enable <= blk;
    cfg_wr_block_side_select <= side;
    @(posedge ref_clk);
    cfg_wr_en <= 2'h0;
    cyc(2);
  endtask : wr

  // start must be absent just after the edge that takes the event and present after the next one
  task automatic raise(input logic [3:0] c, output logic [1:0] early);
    @(posedge ref_clk);
    fire <= 1'b1;
    sel <= c;
    @(posedge ref_clk);
    fire <= 1'b0;
    cyc(1);
    early = start;
    cyc(1);
  endtask : raise

  task automatic t_codes();
    logic v;
    logic a;
    logic [1:0] e;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        v = m ? (c == 1 || c == 3 || (c >= 4 && c <= 10)) : (c == 6 || c == 7);
        a = v && m == 0;
        wr(2'h1, c[3:0], m[0], m[0]);
        chk("factor", activation_factor[0], c[3:0]);
        chk("mode_bits", {block_side_select[0], block_mode_enable[0]}, {m[0], m[0]});
        chk("code_valid", code_valid, {1'b0, v});
        raise(c == 1 ? 4'h8 : 4'h1, e);
        chk("stray_start", start, {1'b0, a});
        raise(v ? c[3:0] : 4'h0, e);
        chk("early_start", e, {1'b0, a});
        chk("start", start, {1'b0, v});
        chk("start_burst", start_burst, {1'b0, a && c == 7});
        cyc(1);
        chk("start_pulse", start, {1'b0, a});
      end
    end
    wr(2'h1, 4'h0, 1'b0, 1'b0);
  endtask : t_codes

  task automatic t_prio();
    logic [1:0] e;
    wr(2'h3, 4'h9, 1'b1, 1'b0);
    raise(4'h9, e);
    chk("first_grant", start, 2'h1);
    cyc(1);
    chk("second_grant", start, 2'h2);
    @(posedge ref_clk);
    chan_enable <= 2'h1;
    raise(4'h3, e);
    chk("usb_grant", start, 2'h0);
    wr(2'h3, 4'h3, 1'b1, 1'b0);
    raise(4'h3, e);
    chk("usb_grant", start, 2'h1);
    cyc(1);
    chk("disabled_grant", start, 2'h0);
  endtask : t_prio

  task automatic t_reset();
    cyc(10);
    chk("reset_outputs", {code_valid, start, start_burst, block_mode_enable}, 8'h00);
    chk("reset_side", block_side_select, 2'h0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(1);
    chk("reset_factor", activation_factor, 8'h00);
  endtask : t_reset

  initial begin
    t_reset();
    t_codes();
    t_prio();
    print_verdict();
  end

  // the sequence needs under a thousand cycles
  initial begin
    #(40 * 4000);
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
